// ==== common/sew_pkg.sv ====
// shared constants and state types for the two-wire memory link
// assumes a 10 MHz system clock on both ends; link timing is derived from it
package sew_pkg;
   // system clock and link rate
   localparam int CLK_HZ = 10_000_000;
   localparam int SCL_HZ = 100_000;
   localparam int QTR_CYCLES = CLK_HZ / (4 * SCL_HZ);
   // internally timed programming, time in ms and derived cycles
   localparam int PROGRAM_CYCLE_TIME_MS = 10;
   localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_MS * (CLK_HZ / 1000);
   // array organisation
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int MEM_WORDS = 128;
   localparam int PAGE_BYTES = 4;
   localparam int PAGE_LSB = 2;
   localparam logic [7:0] PAGE_CNT = 8'h04;
   // bit slot counting within a nine-clock word
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] RECOV_LAST = 4'h8;
   // device link-side states
   typedef enum logic [2:0] {
      D_IDLE = 3'h0,
      D_ADDR = 3'h1,
      D_AACK = 3'h2,
      D_WDATA = 3'h3,
      D_WACK = 3'h4,
      D_RDATA = 3'h5,
      D_RACK = 3'h6
   } sew_dev_state_t;
   // controller states
   typedef enum logic [2:0] {
      C_IDLE = 3'h0,
      C_START = 3'h1,
      C_BIT = 3'h2,
      C_STOP = 3'h3,
      C_RECOV = 3'h4
   } sew_ctl_state_t;
endpackage : sew_pkg

// ==== common/sew_link_if.sv ====
// the two-wire link between controller and memory device
// assumes a pull-up on the data line: it is low only while some end drives it
interface sew_link_if;
   logic scl;         // serial clock, made by the controller
   logic ctl_sda_o;   // controller data out (always low, open drain)
   logic ctl_sda_oe;  // controller pulls data low
   logic dev_sda_o;   // device data out (always low, open drain)
   logic dev_sda_oe;  // device pulls data low
   logic sda;         // resolved wired level

   // wired-and of both open-drain ends with the pull-up
   assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport ctl (output scl, output ctl_sda_o, output ctl_sda_oe, input sda);
   modport dev (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface : sew_link_if

// ==== verilog/sew_dev.sv ====
// two-wire serial memory device: 128 bytes, 4-byte page, timed programming
// assumes i_link_clk oversamples the link (both lines pass two flip-flops)
// and i_clk runs the programming timer; one async reset serves both domains
module sew_dev #(
   parameter int PROG_CYCLES = sew_pkg::PROG_CYCLES
) (
   input wire logic i_clk,       // core clock, runs the programming timer
   input wire logic i_link_clk,  // link sampling clock
   input wire logic i_reset_n,   // async reset, active low
   sew_link_if.dev link,         // serial clock and data pins
   output logic o_busy,          // programming cycle running (i_clk domain)
   output logic o_standby        // idle and not programming (link domain)
);
   localparam int CW = $clog2(PROG_CYCLES + 1);

   // link-domain state
   logic scl_s1_reg, scl_s2_reg, scl_d_reg;
   logic sda_s1_reg, sda_s2_reg, sda_d_reg;
   sew_pkg::sew_dev_state_t state_reg;
   logic [3:0] bitn_reg;
   logic [7:0] shreg_reg;
   logic [6:0] addr_reg;
   logic rw_reg;
   logic rd_ack_reg;
   logic sda_oe_reg;
   logic [sew_pkg::PAGE_BYTES-1:0] pvalid_reg;
   logic pend_reg;
   logic req_tgl_reg;
   logic busy_s1_reg, busy_s2_reg;
   logic standby_reg;
   logic [7:0] pbuf [sew_pkg::PAGE_BYTES];
   logic [7:0] mem [sew_pkg::MEM_WORDS];

   // core-domain state
   logic req_s1_reg, req_s2_reg, req_s3_reg;
   logic busy_reg;
   logic [CW-1:0] cnt_reg;

   // line events, decoded from the synchronised samples only
   wire start_ev = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
   wire stop_ev = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;
   wire scl_rise = scl_s2_reg & ~scl_d_reg;
   wire scl_fall = ~scl_s2_reg & scl_d_reg;
   wire rx_full = (bitn_reg == sew_pkg::BIT_ACK);
   wire dev_busy = pend_reg | busy_s2_reg;
   wire commit = stop_ev & (|pvalid_reg);
   wire wr_store = (state_reg == sew_pkg::D_WDATA) & scl_fall & rx_full;
   wire [6:0] addr_inc = addr_reg + 7'h01;
   wire [1:0] low_inc = addr_reg[1:0] + 2'h1;
   wire [6:0] rd_sel = (state_reg == sew_pkg::D_RACK) ? addr_inc : addr_reg;
   wire [7:0] rd_word = mem[rd_sel];

   // open drain: the output level is low, only the enable moves
   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = sda_oe_reg;
   assign o_standby = standby_reg;
   assign o_busy = busy_reg;

   // two-stage synchronisers plus one delayed copy for edge detection
   always_ff @(posedge i_link_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         busy_s1_reg <= 1'b0;
         busy_s2_reg <= 1'b0;
      end else begin
         scl_s1_reg <= link.scl;
         scl_s2_reg <= scl_s1_reg;
         scl_d_reg <= scl_s2_reg;
         sda_s1_reg <= link.sda;
         sda_s2_reg <= sda_s1_reg;
         sda_d_reg <= sda_s2_reg;
         busy_s1_reg <= busy_reg;
         busy_s2_reg <= busy_s1_reg;
      end
   end

   // word engine; stop beats start beats the per-state clock edges
   always_ff @(posedge i_link_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= sew_pkg::D_IDLE;
         bitn_reg <= 4'h0;
         shreg_reg <= 8'h00;
         addr_reg <= 7'h00;
         rw_reg <= 1'b0;
         rd_ack_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         pvalid_reg <= '0;
      end else if (stop_ev) begin
         state_reg <= sew_pkg::D_IDLE;
         sda_oe_reg <= 1'b0;
         pvalid_reg <= '0;
      end else if (start_ev) begin
         state_reg <= sew_pkg::D_ADDR;
         bitn_reg <= 4'h0;
         sda_oe_reg <= 1'b0;
         pvalid_reg <= '0;  // a write cut by a new start is dropped
      end else begin
         unique case (state_reg)
            sew_pkg::D_IDLE: begin
               sda_oe_reg <= 1'b0;
            end
            sew_pkg::D_ADDR: begin
               if (scl_rise) begin
                  shreg_reg <= {shreg_reg[6:0], sda_s2_reg};
                  bitn_reg <= bitn_reg + 4'h1;
               end else if (scl_fall && rx_full) begin
                  if (dev_busy) begin
                     state_reg <= sew_pkg::D_IDLE;
                  end else begin
                     addr_reg <= shreg_reg[7:1];
                     rw_reg <= shreg_reg[0];
                     sda_oe_reg <= 1'b1;
                     state_reg <= sew_pkg::D_AACK;
                  end
               end
            end
            sew_pkg::D_AACK: begin
               if (scl_fall) begin
                  bitn_reg <= 4'h0;
                  if (rw_reg) begin
                     sda_oe_reg <= ~rd_word[7];
                     shreg_reg <= {rd_word[6:0], 1'b0};
                     state_reg <= sew_pkg::D_RDATA;
                  end else begin
                     sda_oe_reg <= 1'b0;
                     state_reg <= sew_pkg::D_WDATA;
                  end
               end
            end
            sew_pkg::D_WDATA: begin
               if (scl_rise) begin
                  shreg_reg <= {shreg_reg[6:0], sda_s2_reg};
                  bitn_reg <= bitn_reg + 4'h1;
               end else if (wr_store) begin
                  pvalid_reg[addr_reg[1:0]] <= 1'b1;
                  addr_reg[1:0] <= low_inc;
                  sda_oe_reg <= 1'b1;
                  state_reg <= sew_pkg::D_WACK;
               end
            end
            sew_pkg::D_WACK: begin
               if (scl_fall) begin
                  sda_oe_reg <= 1'b0;
                  bitn_reg <= 4'h0;
                  state_reg <= sew_pkg::D_WDATA;
               end
            end
            sew_pkg::D_RDATA: begin
               if (scl_fall) begin
                  if (bitn_reg == sew_pkg::BIT_LAST) begin
                     sda_oe_reg <= 1'b0;  // let the controller answer
                     state_reg <= sew_pkg::D_RACK;
                  end else begin
                     sda_oe_reg <= ~shreg_reg[7];
                     shreg_reg <= {shreg_reg[6:0], 1'b0};
                     bitn_reg <= bitn_reg + 4'h1;
                  end
               end
            end
            sew_pkg::D_RACK: begin
               if (scl_rise) begin
                  rd_ack_reg <= ~sda_s2_reg;
               end else if (scl_fall) begin
                  if (rd_ack_reg) begin
                     addr_reg <= addr_inc;
                     sda_oe_reg <= ~rd_word[7];
                     shreg_reg <= {rd_word[6:0], 1'b0};
                     bitn_reg <= 4'h0;
                     state_reg <= sew_pkg::D_RDATA;
                  end else begin
                     state_reg <= sew_pkg::D_IDLE;
                  end
               end
            end
            default: begin
               state_reg <= sew_pkg::D_IDLE;
            end
         endcase
      end
   end

   // page buffer and array; no reset so the array maps onto plain storage
   always_ff @(posedge i_link_clk) begin
      if (wr_store) begin
         pbuf[addr_reg[1:0]] <= shreg_reg;
      end
      for (int i = 0; i < sew_pkg::PAGE_BYTES; i++) begin
         if (commit && pvalid_reg[i]) begin
            mem[{addr_reg[sew_pkg::ADDR_W-1:sew_pkg::PAGE_LSB], 2'(i)}] <= pbuf[i];
         end
      end
   end

   // hand the commit to the timer; pending covers the crossing delay
   always_ff @(posedge i_link_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         req_tgl_reg <= 1'b0;
         pend_reg <= 1'b0;
         standby_reg <= 1'b1;
      end else begin
         if (commit) begin
            req_tgl_reg <= ~req_tgl_reg;
         end
         if (commit) begin
            pend_reg <= 1'b1;
         end else if (busy_s2_reg) begin
            pend_reg <= 1'b0;
         end
         standby_reg <= (state_reg == sew_pkg::D_IDLE) & ~dev_busy;
      end
   end

   // programming timer in the core domain, length set by PROG_CYCLES
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         req_s3_reg <= 1'b0;
         busy_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         req_s1_reg <= req_tgl_reg;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
         if (req_s2_reg ^ req_s3_reg) begin
            busy_reg <= 1'b1;
            cnt_reg <= CW'(PROG_CYCLES - 1);
         end else if (busy_reg) begin
            if (cnt_reg == '0) begin
               busy_reg <= 1'b0;
            end else begin
               cnt_reg <= cnt_reg - CW'(1);
            end
         end
      end
   end
endmodule : sew_dev

// ==== verilog/sew_ctl.sv ====
// two-wire bus controller for the serial memory: makes the serial clock,
// runs address, page write, read and recovery sequences for a user port
// assumes i_clk at 10 MHz; the data line is sampled through two flip-flops
module sew_ctl #(
   parameter int QTR_CYCLES = sew_pkg::QTR_CYCLES
) (
   input wire logic i_clk,          // system clock
   input wire logic i_reset_n,      // async reset, active low
   sew_link_if.ctl link,            // serial clock and data pins
   input wire logic i_req,          // start a transaction (idle only)
   input wire logic i_rd,           // 1 read, 0 write
   input wire logic [6:0] i_addr,   // word address
   input wire logic [7:0] i_count,  // data bytes; write 0 = poll only
   input wire logic [7:0] i_wdata,  // write byte, held until o_wtake
   input wire logic i_recover,      // run the bus recovery sequence
   output logic o_wtake,            // i_wdata taken, present the next
   output logic [7:0] o_rdata,      // read byte
   output logic o_rvalid,           // o_rdata valid pulse
   output logic o_done,             // transaction finished pulse
   output logic o_nack,             // last transaction got no acknowledge
   output logic o_busy              // transaction running
);
   localparam int QW = $clog2(QTR_CYCLES + 1);

   sew_pkg::sew_ctl_state_t st_reg;
   logic [QW-1:0] qcnt_reg;
   logic [1:0] ph_reg;
   logic [3:0] bitn_reg;
   logic [7:0] shreg_reg;
   logic [7:0] remain_reg;
   logic rw_reg, addr_ph_reg, recov_reg;
   logic scl_reg, sda_oe_reg;
   logic sda_s1_reg, sda_s2_reg;
   logic wtake_reg, rvalid_reg, done_reg, nack_reg, busy_reg;
   logic [7:0] rdata_reg;

   // quarter-period tick; four quarters make one serial clock
   wire tick = (qcnt_reg == QW'(QTR_CYCLES - 1));
   wire ack_slot = (bitn_reg == sew_pkg::BIT_ACK);
   wire rx_mode = rw_reg & ~addr_ph_reg;
   wire is_last = (remain_reg == 8'h01);
   wire sda_in = sda_s2_reg;
   // reads take at least one byte so the stop is never blocked by data
   wire [7:0] rd_cnt = (i_count == 8'h00) ? 8'h01 : i_count;
   wire [7:0] wr_cnt = (i_count > sew_pkg::PAGE_CNT) ? sew_pkg::PAGE_CNT : i_count;
   wire sda_drv = ack_slot ? (rx_mode & ~is_last) : (~rx_mode & ~shreg_reg[7]);

   assign link.scl = scl_reg;
   assign link.ctl_sda_o = 1'b0;
   assign link.ctl_sda_oe = sda_oe_reg;
   assign o_wtake = wtake_reg;
   assign o_rdata = rdata_reg;
   assign o_rvalid = rvalid_reg;
   assign o_done = done_reg;
   assign o_nack = nack_reg;
   assign o_busy = busy_reg;

   // data line synchroniser and quarter counter
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         qcnt_reg <= '0;
      end else begin
         sda_s1_reg <= link.sda;
         sda_s2_reg <= sda_s1_reg;
         if (st_reg == sew_pkg::C_IDLE || tick) begin
            qcnt_reg <= '0;
         end else begin
            qcnt_reg <= qcnt_reg + QW'(1);
         end
      end
   end

   // sequencer; outside C_IDLE, actions happen at the end of each quarter
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg <= sew_pkg::C_IDLE;
         ph_reg <= 2'h0;
         bitn_reg <= 4'h0;
         shreg_reg <= 8'h00;
         remain_reg <= 8'h00;
         rw_reg <= 1'b0;
         addr_ph_reg <= 1'b0;
         recov_reg <= 1'b0;
         scl_reg <= 1'b1;
         sda_oe_reg <= 1'b0;
         wtake_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         done_reg <= 1'b0;
         nack_reg <= 1'b0;
         busy_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         wtake_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         done_reg <= 1'b0;
         if (tick) begin
            ph_reg <= ph_reg + 2'h1;
         end
         unique case (st_reg)
            sew_pkg::C_IDLE: begin
               ph_reg <= 2'h0;
               bitn_reg <= 4'h0;
               if (i_recover) begin
                  st_reg <= sew_pkg::C_RECOV;
                  recov_reg <= 1'b1;
                  busy_reg <= 1'b1;
                  nack_reg <= 1'b0;
               end else if (i_req) begin
                  st_reg <= sew_pkg::C_START;
                  shreg_reg <= {i_addr, i_rd};
                  rw_reg <= i_rd;
                  remain_reg <= i_rd ? rd_cnt : wr_cnt;
                  addr_ph_reg <= 1'b1;
                  busy_reg <= 1'b1;
                  nack_reg <= 1'b0;
               end
            end
            sew_pkg::C_RECOV: begin
               if (tick) begin
                  if (ph_reg == 2'h0) begin
                     scl_reg <= 1'b0;
                  end else if (ph_reg == 2'h1) begin
                     scl_reg <= 1'b1;
                  end else if (ph_reg == 2'h3) begin
                     if (sda_in || bitn_reg == sew_pkg::RECOV_LAST) begin
                        st_reg <= sew_pkg::C_START;
                     end else begin
                        bitn_reg <= bitn_reg + 4'h1;
                     end
                  end
               end
            end
            sew_pkg::C_START: begin
               if (tick) begin
                  if (ph_reg == 2'h0) begin
                     sda_oe_reg <= 1'b1;  // fall with clock high
                  end else if (ph_reg == 2'h2) begin
                     scl_reg <= 1'b0;
                  end else if (ph_reg == 2'h3) begin
                     bitn_reg <= 4'h0;
                     recov_reg <= 1'b0;
                     st_reg <= recov_reg ? sew_pkg::C_STOP : sew_pkg::C_BIT;
                  end
               end
            end
            sew_pkg::C_BIT: begin
               if (tick) begin
                  if (ph_reg == 2'h0) begin
                     sda_oe_reg <= sda_drv;  // data moves only with clock low
                  end else if (ph_reg == 2'h1) begin
                     scl_reg <= 1'b1;
                  end else if (ph_reg == 2'h3) begin
                     scl_reg <= 1'b0;
                     if (!ack_slot) begin
                        shreg_reg <= {shreg_reg[6:0], sda_in};
                        bitn_reg <= bitn_reg + 4'h1;
                     end else begin
                        bitn_reg <= 4'h0;
                        addr_ph_reg <= 1'b0;
                        if (!rx_mode && sda_in) begin
                           nack_reg <= 1'b1;  // busy device or refused word
                           st_reg <= sew_pkg::C_STOP;
                        end else if (rx_mode) begin
                           rdata_reg <= shreg_reg;
                           rvalid_reg <= 1'b1;
                           remain_reg <= remain_reg - 8'h01;
                           if (is_last) begin
                              st_reg <= sew_pkg::C_STOP;
                           end
                        end else if (rw_reg) begin
                           st_reg <= sew_pkg::C_BIT;
                        end else if (remain_reg == 8'h00) begin
                           st_reg <= sew_pkg::C_STOP;
                        end else begin
                           shreg_reg <= i_wdata;
                           wtake_reg <= 1'b1;
                           remain_reg <= remain_reg - 8'h01;
                        end
                     end
                  end
               end
            end
            sew_pkg::C_STOP: begin
               if (tick) begin
                  if (ph_reg == 2'h0) begin
                     sda_oe_reg <= 1'b1;
                  end else if (ph_reg == 2'h1) begin
                     scl_reg <= 1'b1;
                  end else if (ph_reg == 2'h2) begin
                     sda_oe_reg <= 1'b0;  // rise with clock high
                  end else begin
                     st_reg <= sew_pkg::C_IDLE;
                     done_reg <= 1'b1;
                     busy_reg <= 1'b0;
                  end
               end
            end
            default: begin
               st_reg <= sew_pkg::C_IDLE;
            end
         endcase
      end
   end
endmodule : sew_ctl

// ==== tb/sew_link_chk.sv ====
// checker on the two-wire link joining controller and memory device
// assumes i_clk at 10 MHz samples the resolved link signals
module sew_link_chk (
   input wire logic i_clk, // sampling clock
   input wire logic i_reset_n, // async reset, active low
   input wire logic i_scl, // serial clock
   input wire logic i_ctl_sda_oe, // controller pulls data low
   input wire logic i_dev_sda_o, // device data out
   input wire logic i_dev_sda_oe, // device pulls data low
   input wire logic i_sda // resolved data level
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);
   // wire events; the past-scl term keeps a clock edge from passing for one
   sequence s_start;
      i_scl && $past(i_scl) && $fell(i_sda);
   endsequence
   sequence s_stop;
      i_scl && $past(i_scl) && $rose(i_sda);
   endsequence
   property p_dev_od;
      i_dev_sda_oe |-> !i_dev_sda_o;
   endproperty
   a_dev_od: assert property (p_dev_od) else $error("device drives data high");
   property p_start_quiet;
      s_start |-> !i_dev_sda_oe ##1 !i_dev_sda_oe [*8];
   endproperty
   a_start_quiet: assert property (p_start_quiet) else $error("device pulls at start");
   property p_dev_low;
      $changed(i_dev_sda_oe) |-> !i_scl;
   endproperty
   a_dev_low: assert property (p_dev_low) else $error("device data moved, clock high");
   property p_stop_rel;
      s_stop |=> !i_dev_sda_oe [*8];
   endproperty
   a_stop_rel: assert property (p_stop_rel) else $error("device drives after stop");
   property p_ack_hold;
      $rose(i_scl) && i_dev_sda_oe |=> i_dev_sda_oe [*8];
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("device low bit not held");
   property p_no_fight;
      i_scl |-> !(i_ctl_sda_oe && i_dev_sda_oe);
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("both ends pull data");
   property p_ctl_edge;
      i_scl && $past(i_scl) && $changed(i_ctl_sda_oe) |-> $changed(i_sda);
   endproperty
   a_ctl_edge: assert property (p_ctl_edge) else $error("controller edge lost");
   property p_start_hold;
      s_start |=> i_scl [*8];
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("clock fell after start");
endmodule : sew_link_chk

// ==== tb/serial_eeprom_two_wire_slave_bench.sv ====
// bench: controller and memory device joined over the two-wire link
// assumes both ends, the link interface and the package are compiled first
module serial_eeprom_two_wire_slave_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk, i_link_clk, i_reset_n, req, rd, rec;
   logic wtake, rvalid, done, nack, cbusy, dbusy, standby;
   logic [6:0] addr;
   logic [7:0] cnt, rdata;
   logic [7:0] wbuf [0:3];
   logic [7:0] rbuf [0:3];
   logic [7:0] expd [0:3];
   int widx, ridx, err_count, comparisons;
   sew_link_if link ();
   sew_ctl u_sew_ctl (.i_clk(i_clk), .i_reset_n(i_reset_n), .link(link), .i_req(req),
      .i_rd(rd), .i_addr(addr), .i_count(cnt), .i_wdata(wbuf[widx[1:0]]), .i_recover(rec),
      .o_wtake(wtake), .o_rdata(rdata), .o_rvalid(rvalid), .o_done(done), .o_nack(nack),
      .o_busy(cbusy));
   // long programming so the first poll lands inside it
   sew_dev #(.PROG_CYCLES(1500)) u_sew_dev (.i_clk(i_clk), .i_link_clk(i_link_clk),
      .i_reset_n(i_reset_n), .link(link), .o_busy(dbusy), .o_standby(standby));
   sew_link_chk u_sew_link_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(link.scl),
      .i_ctl_sda_oe(link.ctl_sda_oe), .i_dev_sda_o(link.dev_sda_o),
      .i_dev_sda_oe(link.dev_sda_oe), .i_sda(link.sda));
   // clocks: link clock unrelated in phase
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   initial begin
      i_link_clk = 1'b0;
      #7;
      forever #24 i_link_clk = ~i_link_clk;
   end
   // step write bytes and collect read bytes, sampled off the edge; the indexes
   // rest at zero while the controller idles, so this block is their only driver
   always @(negedge i_clk) begin
      if (cbusy !== 1'b1) widx <= 0;
      else if (wtake === 1'b1) widx <= widx + 1;
      if (cbusy !== 1'b1) ridx <= 0;
      else if (rvalid === 1'b1) ridx <= ridx + 1;
      if (rvalid === 1'b1) rbuf[ridx[1:0]] <= rdata;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("counts: %0d compared, %0d bad", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // one controller transaction, waited for under a bound
   task automatic run(input logic r, input logic d, input logic [6:0] a, input logic [7:0] n);
      int k;
      @(negedge i_clk);
      {rec, req, rd, addr, cnt} = {r, ~r, d, a, n};
      @(negedge i_clk);
      {rec, req} = 2'b00;
      for (k = 0; k < 30000 && done !== 1'b1; k++) @(negedge i_clk);
      if (k == 30000) begin
         err_count++;
         print_verdict();
      end else begin
         check(8'(cbusy), 8'h00);
         $display("test done: rd %b addr %h count %0d", d, a, n);
      end
   endtask : run
   // poll until the address is acknowledged
   task automatic wait_ready();
      int p;
      for (p = 0; p < 20 && (p == 0 || nack !== 1'b0); p++) run(1'b0, 1'b0, 7'h00, 8'h00);
      if (p == 20) begin
         err_count++;
         print_verdict();
      end
   endtask : wait_ready
   task automatic readback(input logic [6:0] a, input logic [7:0] n);
      run(1'b0, 1'b1, a, n);
      for (int i = 0; i < n; i++) check(rbuf[i], expd[i]);
      repeat (8) @(negedge i_clk);
      check(8'(standby), 8'h01);
   endtask : readback
   initial begin
      {i_reset_n, req, rd, rec, addr, cnt, err_count, comparisons} = '0;
      wbuf = '{8'h5A, 8'h3C, 8'h96, 8'h0F};
      repeat (12) @(negedge i_clk);
      i_reset_n = 1'b1;
      check(8'(standby), 8'h01);
      run(1'b0, 1'b0, 7'h00, 8'h01);
      check(8'(nack), 8'h00);
      repeat (10) @(negedge i_clk);
      check({6'h00, standby, dbusy}, 8'h01);
      run(1'b0, 1'b0, 7'h00, 8'h00);
      check(8'(nack), 8'h01);
      wait_ready();
      check(8'(nack), 8'h00);
      wbuf[0] = 8'hA5;
      run(1'b0, 1'b0, 7'h7E, 8'h04);
      wait_ready();
      expd = '{8'h96, 8'h0F, 8'hA5, 8'h3C};
      readback(7'h7C, 8'h04);
      expd[0] = 8'h3C;
      expd[1] = 8'h5A;
      readback(7'h7F, 8'h02);
      run(1'b1, 1'b0, 7'h00, 8'h00);
      expd[0] = 8'h5A;
      readback(7'h00, 8'h01);
      print_verdict();
   end
endmodule : serial_eeprom_two_wire_slave_bench
